// File: verilog/tpt_timers.sv
// Three programmable timers with pins, demodulation gating and shared interrupt.
// What this block does
// - Three independent timers with 16-bit counts; watchdog lives elsewhere.
// - Timers 0 and 1 each count an input pin and drive an output pin.
// - Timers 0 and 1 time the high and low phases of the demodulation input.
// - Timer 2 has no pins; it times delays, prescales, and paces DMA.
// - Eleven 16-bit control registers steer the timers from outside.
// - Count always holds present value; writable any time, running or not.
// - Each qualifying event adds one to the timer count.
// - Count clears to zero when it reaches the active limit; limit never held.
// - Timers 0 and 1 alternate primary and secondary limits at each terminal count.
// - Primary only: output pin low one clock at terminal count, else high.
// - Both limits: output pin level shows which limit is in control.
// - Timers are evaluated once every four clocks.
// - External clocking: output may lag the input edge by up to seven clocks.
// - One shared interrupt; timer 0 highest priority, timer 2 lowest.
// - Interrupt type codes are programmable in slave mode.
// - Terminal count sets a sticky flag and, if enabled, requests interrupt.
`timescale 1ns/1ps
module tpt_timers
    import tpt_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Timer mode controls
    input  wire logic [2:0]  tmr_en,
    input  wire logic [2:0]  tmr_cont,
    input  wire logic [2:0]  tmr_int_en,
    input  wire logic [1:0]  tmr_ext_clk,
    input  wire logic [1:0]  tmr_prescale,
    input  wire logic [1:0]  tmr_alt,
    input  wire logic [15:0] max_a [TPT_NTMR],
    input  wire logic [15:0] max_b [TPT_NEXT],
    // Count access
    input  wire logic [2:0]  cnt_wr,
    input  wire logic [15:0] cnt_wdata [TPT_NTMR],
    output logic      [15:0] cnt [TPT_NTMR],
    // Flags and interrupt
    input  wire logic [2:0]  tc_flag_clr,
    input  wire logic        slave_mode,
    input  wire logic [7:0]  slave_type [TPT_NTMR],
    output logic      [2:0]  terminal_count_flag,
    output logic             irq,
    output logic      [7:0]  irq_type,
    output logic      [1:0]  irq_src,
    // Pins and internal pacing
    input  wire logic [1:0]  tmr_in,
    input  wire logic        pwd_en,
    input  wire logic        pwd_in,
    output logic      [1:0]  tmr_out,
    output logic             t2_dma_req
);

    // ****************************************************************
    // Poll phase
    // ****************************************************************
    tpt_phase_t phase;
    tpt_phase_t next_phase;
    wire        tick = phase == TPT_PH3;

    always_comb begin
        unique case (phase)
            TPT_PH0: next_phase = TPT_PH1;
            TPT_PH1: next_phase = TPT_PH2;
            TPT_PH2: next_phase = TPT_PH3;
            TPT_PH3: next_phase = TPT_PH0;
            default: next_phase = TPT_PH0;
        endcase
    end

    // Polling every fourth clock keeps event decode off the critical path.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase <= TPT_PH0;
        end else begin
            phase <= next_phase;
        end
    end

    // ****************************************************************
    // Pin synchronisers and edge capture
    // ****************************************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] prev;
    logic [1:0] pend;
    wire  [1:0] rise    = sync2[1:0] & ~prev;
    wire  [1:0] edge_in = pend | rise;
    wire        pwd_lvl = sync2[2];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            prev  <= 2'h0;
            pend  <= 2'h0;
        end else begin
            sync1 <= {pwd_in, tmr_in};
            sync2 <= sync1;
            prev  <= sync2[1:0];
            pend  <= tick ? 2'h0 : edge_in;
        end
    end

    // ****************************************************************
    // Event selection and counters
    // ****************************************************************
    logic [2:0]  ev;
    logic [2:0]  tc_w;
    logic [2:0]  useb_w;
    wire  [2:0]  alt_w = {1'b0, tmr_alt};
    wire  [15:0] maxb_w [TPT_NTMR];

    assign maxb_w[0] = max_b[0];
    assign maxb_w[1] = max_b[1];
    assign maxb_w[2] = TPT_CNT_RST;
    assign ev[2]     = tick;

    genvar i;
    generate
        for (i = 0; i < TPT_NEXT; i++) begin : g_ext
            localparam logic PHASE_HI = (i == 0);
            wire ev_pwd = tick & (pwd_lvl == PHASE_HI);
            wire ev_ext = tick & edge_in[i];
            assign ev[i] = pwd_en ? ev_pwd
                         : tmr_prescale[i] ? tc_w[2]
                         : tmr_ext_clk[i] ? ev_ext : tick;

            // Output pins idle high so a lone limit shows as a low blip.
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    tmr_out[i] <= 1'b1;
                end else if (tmr_alt[i]) begin
                    tmr_out[i] <= ~useb_w[i];
                end else begin
                    tmr_out[i] <= ~tc_w[i];
                end
            end

            sequence s_low_blip;
                !tmr_out[i] ##1 tmr_out[i];
            endsequence
            property p_blip;
                @(posedge core_clk) disable iff (rst)
                (tc_w[i] && !tmr_alt[i] && !$past(tc_w[i])) |=> s_low_blip;
            endproperty
            a_blip: assert property (p_blip) else $error("output low pulse wrong");

            property p_level;
                @(posedge core_clk) disable iff (rst)
                tmr_alt[i] |=> tmr_out[i] == !$past(useb_w[i]);
            endproperty
            a_level: assert property (p_level) else $error("output level wrong");

            property p_ext_lag;
                @(posedge core_clk) disable iff (rst)
                (tmr_ext_clk[i] && !tmr_prescale[i] && !pwd_en && rise[i])
                    |-> ##[0:3] ev[i];
            endproperty
            a_ext_lag: assert property (p_ext_lag) else $error("external edge late");
        end

        for (i = 0; i < TPT_NTMR; i++) begin : g_cnt
            tpt_counter u_cnt (
                .core_clk (core_clk),
                .rst      (rst),
                .en       (tmr_en[i]),
                .cont     (tmr_cont[i]),
                .alt      (alt_w[i]),
                .max_a    (max_a[i]),
                .max_b    (maxb_w[i]),
                .event_in (ev[i]),
                .wr       (cnt_wr[i]),
                .wdata    (cnt_wdata[i]),
                .count    (cnt[i]),
                .tc       (tc_w[i]),
                .use_b    (useb_w[i])
            );
        end
    endgenerate

    // ****************************************************************
    // Flags and shared interrupt
    // ****************************************************************
    wire [2:0] req      = terminal_count_flag & tmr_int_en;
    wire [1:0] next_src = req[0] ? TPT_SRC_T0 : req[1] ? TPT_SRC_T1 : TPT_SRC_T2;
    wire [7:0] def_type = req[0] ? TPT_TYPE_T0 : req[1] ? TPT_TYPE_T1 : TPT_TYPE_T2;
    wire [7:0] next_type = slave_mode ? slave_type[next_src] : def_type;

    // A terminal count landing on a clear keeps its flag set.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            terminal_count_flag <= 3'h0;
            irq                 <= 1'b0;
            irq_type            <= TPT_TYPE_T0;
            irq_src             <= TPT_SRC_T0;
            t2_dma_req          <= 1'b0;
        end else begin
            terminal_count_flag <= (terminal_count_flag & ~tc_flag_clr) | tc_w;
            irq                 <= |req;
            irq_type            <= next_type;
            irq_src             <= next_src;
            t2_dma_req          <= tc_w[2];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_poll;
        @(posedge core_clk) disable iff (rst)
        tick |=> !tick [*3] ##1 tick;
    endproperty
    a_poll: assert property (p_poll) else $error("poll spacing not four");

    property p_flag;
        @(posedge core_clk) disable iff (rst)
        |tc_w |=> (terminal_count_flag & $past(tc_w)) == $past(tc_w);
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");

    property p_prio;
        @(posedge core_clk) disable iff (rst)
        req[0] |=> irq && irq_src == TPT_SRC_T0;
    endproperty
    a_prio: assert property (p_prio) else $error("timer0 not first");

    property p_slave_type;
        @(posedge core_clk) disable iff (rst)
        (slave_mode && req == 3'h2) |=> irq_type == $past(slave_type[1]);
    endproperty
    a_slave_type: assert property (p_slave_type) else $error("slave type wrong");

    property p_prescale;
        @(posedge core_clk) disable iff (rst)
        (tmr_prescale[1] && !pwd_en && tc_w[2] && tmr_en[1] && tmr_cont[1] && !cnt_wr[1])
            |=> tc_w[1] || cnt[1] != $past(cnt[1]);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale event lost");

endmodule

// File: pkg/tpt_pkg.sv
// Shared constants and types for the triple programmable timer.
package tpt_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int TPT_NTMR = 3;
    localparam int TPT_NEXT = 2;

    // ****************************************************************
    // Count values and interrupt codes
    // ****************************************************************
    localparam logic [15:0] TPT_CNT_RST = 16'h0000;
    localparam logic [15:0] TPT_CNT_ONE = 16'h0001;
    localparam logic [7:0]  TPT_TYPE_T0 = 8'h08;
    localparam logic [7:0]  TPT_TYPE_T1 = 8'h12;
    localparam logic [7:0]  TPT_TYPE_T2 = 8'h13;
    localparam logic [1:0]  TPT_SRC_T0  = 2'h0;
    localparam logic [1:0]  TPT_SRC_T1  = 2'h1;
    localparam logic [1:0]  TPT_SRC_T2  = 2'h2;

    // ****************************************************************
    // Poll phase, one timer evaluation every four clocks
    // ****************************************************************
    typedef enum logic [3:0] {
        TPT_PH0 = 4'b0001,
        TPT_PH1 = 4'b0010,
        TPT_PH2 = 4'b0100,
        TPT_PH3 = 4'b1000
    } tpt_phase_t;

endpackage

// File: verilog/tpt_counter.sv
// One 16-bit timer count with primary and secondary limits.
`timescale 1ns/1ps
module tpt_counter
    import tpt_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Mode
    input  wire logic        en,
    input  wire logic        cont,
    input  wire logic        alt,
    input  wire logic [15:0] max_a,
    input  wire logic [15:0] max_b,
    // Event and count access
    input  wire logic        event_in,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] count,
    output logic             tc,
    output logic             use_b
);

    logic        halted;
    wire  [15:0] active_max = use_b ? max_b : max_a;
    wire  [15:0] inc        = count + TPT_CNT_ONE;
    wire         running    = en & ~halted;
    wire         step       = event_in & running & ~wr;
    wire         hit        = inc == active_max;
    wire         wrap       = step & hit;
    wire         last       = wrap & ~cont & (~alt | use_b);

    // A software write wins over a count step in the same cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= TPT_CNT_RST;
        end else if (wr) begin
            count <= wdata;
        end else if (wrap) begin
            count <= TPT_CNT_RST;
        end else if (step) begin
            count <= inc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tc     <= 1'b0;
            use_b  <= 1'b0;
            halted <= 1'b0;
        end else begin
            tc     <= wrap;
            use_b  <= alt & (use_b ^ wrap);
            halted <= en & (halted | last);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_wrap_zero;
        @(posedge core_clk) disable iff (rst)
        wrap |=> tc && count == TPT_CNT_RST;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count not cleared at limit");

    property p_step_inc;
        @(posedge core_clk) disable iff (rst)
        (step && !hit) |=> count == $past(count) + TPT_CNT_ONE;
    endproperty
    a_step_inc: assert property (p_step_inc) else $error("count did not advance");

    property p_write;
        @(posedge core_clk) disable iff (rst)
        wr |=> count == $past(wdata);
    endproperty
    a_write: assert property (p_write) else $error("count write lost");

    property p_alt_swap;
        @(posedge core_clk) disable iff (rst)
        (wrap && alt) |=> use_b != $past(use_b);
    endproperty
    a_alt_swap: assert property (p_alt_swap) else $error("limit did not alternate");

endmodule

// File: verification/tpt_pin_model.sv
// Pin-side model that drives the timer input pins and the demodulation input.
`timescale 1ns/1ps
module tpt_pin_model
    import tpt_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Pins
    input  wire logic [1:0] tmr_out,
    output logic      [1:0] tmr_in,
    output logic            pwd_in
);
    initial begin
        tmr_in = 2'h0;
        pwd_in = 1'b0;
    end
    // Each level is held eight clocks, so the four-clock poll always sees it.
    task automatic pulse(input int i);
        @(posedge core_clk);
        #1 tmr_in[i] = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 tmr_in[i] = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    task automatic phase(input logic v, input int n);
        @(posedge core_clk);
        #1 pwd_in = v;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
endmodule

// File: verification/test_tpt_timers.sv
// Self-checking testbench for the triple programmable timer.
`timescale 1ns/1ps
module test_tpt_timers
    import tpt_pkg::*;
;
    logic        core_clk, rst, slave_mode, irq, pwd_en, pwd_in, t2_dma_req;
    logic [2:0]  tmr_en, tmr_cont, tmr_int_en, cnt_wr, tc_flag_clr, terminal_count_flag;
    logic [1:0]  tmr_ext_clk, tmr_prescale, tmr_alt, tmr_in, tmr_out, irq_src;
    logic [15:0] max_a [TPT_NTMR];
    logic [15:0] max_b [TPT_NEXT];
    logic [15:0] cnt_wdata [TPT_NTMR];
    logic [15:0] cnt [TPT_NTMR];
    logic [7:0]  slave_type [TPT_NTMR];
    logic [7:0]  irq_type;
    int          n_errors, check_count;

    tpt_timers dut_u (.core_clk(core_clk), .rst(rst), .tmr_en(tmr_en), .tmr_cont(tmr_cont),
        .tmr_int_en(tmr_int_en), .tmr_ext_clk(tmr_ext_clk), .tmr_prescale(tmr_prescale),
        .tmr_alt(tmr_alt), .max_a(max_a), .max_b(max_b), .cnt_wr(cnt_wr),
        .cnt_wdata(cnt_wdata), .cnt(cnt), .tc_flag_clr(tc_flag_clr), .slave_mode(slave_mode),
        .slave_type(slave_type), .terminal_count_flag(terminal_count_flag), .irq(irq),
        .irq_type(irq_type), .irq_src(irq_src), .tmr_in(tmr_in), .pwd_en(pwd_en),
        .pwd_in(pwd_in), .tmr_out(tmr_out), .t2_dma_req(t2_dma_req));
    tpt_pin_model pin_u (.core_clk(core_clk), .tmr_out(tmr_out), .tmr_in(tmr_in),
        .pwd_in(pwd_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // Inputs always change 1 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr_all(input logic [2:0] sel, input logic [15:0] v);
        cnt_wr = sel;
        foreach (cnt_wdata[i]) cnt_wdata[i] = v;
        step(1);
        cnt_wr = 3'h0;
    endtask
    task automatic clear_all();
        tmr_en = 3'h0;
        tc_flag_clr = 3'h7;
        step(1);
        tc_flag_clr = 3'h0;
        step(2);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values are looked at while reset still holds; once released, an idle
    // interrupt encoder reports the lowest source.
    task automatic t_reset();
        chk(cnt[0] === TPT_CNT_RST && cnt[2] === TPT_CNT_RST, "count reset");
        chk(terminal_count_flag === 3'h0 && irq === 1'b0 && tmr_out === 2'h3, "reset");
        chk(irq_type === TPT_TYPE_T0 && irq_src === TPT_SRC_T0, "reset irq");
        rst = 1'b0;
        step(1);
        chk(irq_type === TPT_TYPE_T2 && irq_src === TPT_SRC_T2, "idle irq");
        chk(cnt[1] === TPT_CNT_RST && t2_dma_req === 1'b0, "idle");
    endtask
    task automatic t_write();
        cnt_wr = 3'h4;
        cnt_wdata[2] = 16'hBEEF;
        step(1);
        chk(cnt[2] === 16'hBEEF, "write");
        cnt_wdata[2] = 16'h1234;
        step(1);
        cnt_wr = 3'h0;
        chk(cnt[2] === 16'h1234, "back to back write");
    endtask
    task automatic t_primary();
        int n;
        max_a[0] = 16'h0002;
        tmr_cont = 3'h7;
        tmr_int_en = 3'h7;
        wr_all(3'h1, TPT_CNT_RST);
        tmr_en[0] = 1'b1;
        n = 0;
        while (cnt[0] !== TPT_CNT_ONE && n < 20) begin step(1); n++; end
        n = 0;
        while (cnt[0] === TPT_CNT_ONE && n < 10) begin step(1); n++; end
        chk(n == 4 && cnt[0] === TPT_CNT_RST, "limit clear or poll rate");
        step(1);
        chk(terminal_count_flag[0] === 1'b1 && tmr_out[0] === 1'b0, "flag pin");
        step(1);
        chk(tmr_out[0] === 1'b1 && irq === 1'b1, "pin high or irq");
        clear_all();
    endtask
    task automatic t_alt();
        int n;
        max_a[1] = 16'h0002;
        max_b[1] = 16'h0003;
        tmr_alt = 2'h2;
        wr_all(3'h2, TPT_CNT_RST);
        tmr_en[1] = 1'b1;
        n = 0;
        while (tmr_out[1] !== 1'b0 && n < 60) begin step(1); n++; end
        n = 0;
        while (tmr_out[1] === 1'b0 && n < 40) begin step(1); n++; end
        chk(n == 12, "secondary phase length");
        n = 0;
        while (tmr_out[1] === 1'b1 && n < 40) begin step(1); n++; end
        chk(n == 8, "primary phase length");
        tmr_alt = 2'h0;
        clear_all();
    endtask
    task automatic t_ext();
        max_a[0] = TPT_CNT_RST;
        tmr_ext_clk = 2'h1;
        wr_all(3'h1, TPT_CNT_RST);
        tmr_en[0] = 1'b1;
        for (int k = 1; k <= 3; k++) begin
            pin_u.pulse(0);
            chk(cnt[0] === 16'(k), "external count");
        end
        tmr_ext_clk = 2'h0;
        clear_all();
    endtask
    task automatic t_prio();
        int n;
        foreach (max_a[i]) max_a[i] = 16'h0005;
        wr_all(3'h7, 16'h0004);
        tmr_en = 3'h7;
        n = 0;
        while (terminal_count_flag !== 3'h7 && n < 12) begin step(1); n++; end
        tmr_en = 3'h0;
        step(1);
        chk(irq === 1'b1 && irq_src === TPT_SRC_T0 && irq_type === TPT_TYPE_T0, "t0");
        // Timer 2 is cleared too, so timer 1 is left pending alone.
        tc_flag_clr = 3'h5;
        step(1);
        tc_flag_clr = 3'h0;
        step(1);
        chk(irq_src === TPT_SRC_T1 && irq_type === TPT_TYPE_T1, "t1 next");
        slave_mode = 1'b1;
        slave_type[1] = 8'h5A;
        step(2);
        chk(irq_type === 8'h5A, "slave type");
        slave_mode = 1'b0;
        clear_all();
        chk(irq === 1'b0 && irq_src === TPT_SRC_T2, "irq idle");
    endtask
    // One-shot timer 0 stops at zero after its limit; its flag stays masked from irq.
    task automatic t_oneshot();
        int n;
        max_a[0] = 16'h0002;
        tmr_cont = 3'h6;
        tmr_int_en = 3'h6;
        wr_all(3'h1, TPT_CNT_RST);
        tmr_en[0] = 1'b1;
        n = 0;
        while (terminal_count_flag[0] !== 1'b1 && n < 20) begin step(1); n++; end
        step(12);
        chk(n < 20 && cnt[0] === TPT_CNT_RST && irq === 1'b0, "one shot or mask");
        tmr_cont = 3'h7;
        tmr_int_en = 3'h7;
        clear_all();
    endtask
    task automatic t_prescale();
        int n;
        int p;
        max_a[2] = 16'h0003;
        max_a[1] = TPT_CNT_RST;
        tmr_prescale = 2'h2;
        wr_all(3'h6, TPT_CNT_RST);
        tmr_en = 3'h6;
        n = 0;
        p = 0;
        while (p < 2 && n < 60) begin step(1); n++; if (t2_dma_req === 1'b1) p++; end
        step(2);
        chk(p == 2 && cnt[1] === 16'h0002, "prescaled count");
        tmr_prescale = 2'h0;
        clear_all();
    endtask
    task automatic t_pwd();
        logic [15:0] c0;
        max_a[0] = TPT_CNT_RST;
        pwd_en = 1'b1;
        pin_u.phase(1'b1, 8);
        wr_all(3'h3, TPT_CNT_RST);
        tmr_en = 3'h3;
        pin_u.phase(1'b1, 40);
        chk(cnt[0] >= 16'h0008 && cnt[1] === TPT_CNT_RST, "high phase");
        pin_u.phase(1'b0, 8);
        c0 = cnt[0];
        pin_u.phase(1'b0, 40);
        chk(cnt[0] === c0 && cnt[1] >= 16'h0008, "low phase");
        clear_all();
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
    initial begin
        {rst, slave_mode, pwd_en} = 3'b100;
        {tmr_en, tmr_cont, tmr_int_en, cnt_wr, tc_flag_clr} = 15'h0000;
        {tmr_ext_clk, tmr_prescale, tmr_alt} = 6'h00;
        foreach (max_a[i]) max_a[i] = TPT_CNT_RST;
        foreach (max_b[i]) max_b[i] = TPT_CNT_RST;
        foreach (cnt_wdata[i]) cnt_wdata[i] = TPT_CNT_RST;
        foreach (slave_type[i]) slave_type[i] = 8'h00;
        n_errors = 0;
        check_count = 0;
        step(12);
        t_reset();
        t_write();
        t_primary();
        t_alt();
        t_ext();
        t_prio();
        t_oneshot();
        t_prescale();
        t_pwd();
        summarize();
    end
endmodule
